// >>> hw/sqsp_defines.vh
// constants for the sample sequencer status block
`ifndef SQSP_DEFINES_VH
`define SQSP_DEFINES_VH

// avalon word indexes, byte address is four times the index
`define SQSP_REG_CTRL        2'h0
`define SQSP_REG_STATUS      2'h1
`define SQSP_REG_RESULT      2'h2
`define SQSP_REG_FLAGS       2'h3

// control register fields
`define SQSP_CTRL_RUN_BIT    0
`define SQSP_CTRL_RES_LSB    1
`define SQSP_CTRL_RES_MSB    2
`define SQSP_CTRL_RTC_BIT    3
`define SQSP_CTRL_RESET      4'h0

// resolution modes
`define SQSP_RES_12          2'h0
`define SQSP_RES_10          2'h1
`define SQSP_RES_8           2'h2

// sequencer word fields
`define SQSP_SEQ_CH_MSB      4
`define SQSP_SEQ_WAIT_BIT    5
`define SQSP_SEQ_END_BIT     6

// eval and threshold word fields
`define SQSP_EVAL_BELOW_BIT  0
`define SQSP_THR_EN_BIT      8
`define SQSP_THR_VAL_MSB     7

// status register fields
`define SQSP_STAT_SLOT_MSB   5
`define SQSP_STAT_INIT_BIT   6
`define SQSP_STAT_SAT_BIT    7
`define SQSP_STAT_ST_LSB     8
`define SQSP_STAT_ST_MSB     14

// memory sizes and counts
`define SQSP_SEQ_LAST        6'h3F
`define SQSP_CH_LAST         6'h1F
`define SQSP_WAIT_CYCLES     4'h4
`define SQSP_RESULT_RESET    12'h000
`define SQSP_FLAGS_RESET     32'h00000000

`endif

// >>> hw/sqsp_result_fmt.v
// formats a raw converter word for the chosen resolution and detects saturation
`timescale 1ns/1ps
`include "sqsp_defines.vh"

module sqsp_result_fmt (
    input  wire [11:0] raw_result,
    input  wire [1:0]  res_mode,
    output reg  [11:0] fmt_result,
    output reg         fmt_saturated
);

    always @*
    begin
        fmt_result    = raw_result;
        fmt_saturated = 1'b0;
        case (res_mode)
            `SQSP_RES_10:
            begin
                fmt_result    = {raw_result[11:2], 2'h0}; // [RULE14]
                fmt_saturated = (raw_result[11:2] == 10'h3FF);
            end
            `SQSP_RES_8:
            begin
                fmt_result    = {raw_result[11:4], 4'h0}; // [RULE14]
                fmt_saturated = (raw_result[11:4] == 8'hFF);
            end
            default:
            begin
                fmt_result    = raw_result;
                fmt_saturated = (raw_result == 12'hFFF);
            end
        endcase
    end

endmodule

// >>> hw/sqsp_sequencer_top.v
// sample sequencer with init loading, status outputs and avalon control
// What this block does
// [RULE1] every port is active high except the reset, which is active low.
// [RULE2] a low level on the system reset clears the block at once, without a clock edge.
// [RULE3] one system clock runs the converter control and all sequencing, evaluation and threshold logic.
// [RULE4] during init a nine-bit word is stored into the memory whose load enable is high.
// [RULE5] the loader gives separate enables for the config mux, sequencer, evaluator and threshold memories.
// [RULE6] the loader raises init done when loading has finished.
// [RULE7] a second-pass config mux enable is honoured only when the real-time counter option is on.
// [RULE8] result valid is high while the presented converter result is valid.
// [RULE9] slot complete pulses when the sequencer finishes the current slot.
// [RULE10] slot wait is high while wait states are inserted for evaluation and thresholds.
// [RULE11] saturation goes high on a full-scale result and holds until the next slot starts.
// [RULE12] channel captured pulses once the five-bit channel selector has been latched.
// [RULE13] one compare flag per channel shows that channel's configured threshold condition.
// [RULE14] ten-bit results sit in bits 11:2 with 1:0 zero, eight-bit in 11:4 with 3:0 zero.
// [RULE15] after reset the sequencer starts the main procedure at slot 0.
// [RULE16] the loader raises load enables only before init done and at most one per clock.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sqsp_defines.vh"

module sqsp_sequencer_top (
    input  wire        core_clk,
    input  wire        system_reset_low,
    input  wire [8:0]  init_data,
    input  wire        init_done,
    input  wire        cfg_mux_load_en,
    input  wire        seq_ram_load_en,
    input  wire        eval_ram_load_en,
    input  wire        thresh_ram_load_en,
    input  wire        cfg_mux_second_pass_en,
    input  wire [11:0] adc_result_raw,
    input  wire        adc_conv_done,
    output reg  [4:0]  conv_channel_select,
    output reg         conv_start,
    output reg  [11:0] conv_result_port,
    output reg         conv_result_valid,
    output reg         slot_complete,
    output reg         slot_wait_state,
    output reg         channel_saturated,
    output reg         channel_sel_captured,
    output reg  [31:0] compare_flags,
    input  wire [1:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest
);

    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_LATCH = 7'h02;
    localparam [6:0] ST_ACQ   = 7'h04;
    localparam [6:0] ST_CONV  = 7'h08;
    localparam [6:0] ST_EVAL  = 7'h10;
    localparam [6:0] ST_WAIT  = 7'h20;
    localparam [6:0] ST_DONE  = 7'h40;

    // memories held in flip-flops, addressed by load counters
    reg  [8:0]  seq_mem_ff  [0:63];
    reg  [8:0]  eval_mem_ff [0:31];
    reg  [8:0]  thr_mem_ff  [0:31];
    reg  [8:0]  cfg_mem_ff  [0:31];

    reg  [5:0]  seq_addr_ff;
    reg  [5:0]  eval_addr_ff;
    reg  [5:0]  thr_addr_ff;
    reg  [5:0]  cfg_addr_ff;
    reg         second_pass_ff;

    reg  [6:0]  state_ff;
    reg  [6:0]  nxt_state;
    reg  [5:0]  slot_ff;
    reg  [4:0]  ch_ff;
    reg  [3:0]  acq_cnt_ff;
    reg  [3:0]  wait_cnt_ff;
    reg         init_seen_ff;

    reg  [3:0]  ctrl_ff;
    reg         bus_ack_pending_ff;

    wire [8:0]  seq_word;
    wire [11:0] fmt_result;
    wire        fmt_saturated;
    wire        ctrl_run;
    wire [1:0]  ctrl_res;
    wire        ctrl_rtc;
    wire        bus_req;
    wire        bus_fire;
    wire        cfg_load;

    integer     i;

    // next load address, wrapping at the memory's last entry
    function [5:0] addr_inc;
        input [5:0] addr;
        input [5:0] last;
        begin
            if (addr == last)
                addr_inc = 6'h00;
            else
                addr_inc = addr + 6'h01;
        end
    endfunction

    // one channel's compare result from its eval and threshold words
    function flag_eval;
        input [8:0]  eval_word;
        input [8:0]  thr_word;
        input [11:0] result;
        begin
            if (!thr_word[`SQSP_THR_EN_BIT])
                flag_eval = 1'b0;
            else if (eval_word[`SQSP_EVAL_BELOW_BIT])
                flag_eval = (result[11:4] < thr_word[`SQSP_THR_VAL_MSB:0]);
            else
                flag_eval = (result[11:4] > thr_word[`SQSP_THR_VAL_MSB:0]);
        end
    endfunction

    assign ctrl_run = ctrl_ff[`SQSP_CTRL_RUN_BIT];
    assign ctrl_res = ctrl_ff[`SQSP_CTRL_RES_MSB:`SQSP_CTRL_RES_LSB];
    assign ctrl_rtc = ctrl_ff[`SQSP_CTRL_RTC_BIT];
    assign seq_word = seq_mem_ff[slot_ff];
    assign bus_req  = avs_read | avs_write;
    // the request is answered on the edge where waitrequest is already low
    assign bus_fire = bus_req & ~avs_waitrequest;
    // the second pass reloads the config mux only when the rtc option is on
    assign cfg_load = cfg_mux_load_en | (cfg_mux_second_pass_en & ctrl_rtc); // [RULE7]

    sqsp_result_fmt u_fmt (
        .raw_result    (adc_result_raw),
        .res_mode      (ctrl_res),
        .fmt_result    (fmt_result),
        .fmt_saturated (fmt_saturated)
    );

    // memory loading; loads after init done are dropped so a late enable cannot
    // corrupt a running sequence
    always @(posedge core_clk or negedge system_reset_low) // [RULE2] [RULE3]
    begin
        if (!system_reset_low)
        begin
            for (i = 0; i < 64; i = i + 1)
                seq_mem_ff[i] <= 9'h000;
            for (i = 0; i < 32; i = i + 1)
            begin
                eval_mem_ff[i] <= 9'h000;
                thr_mem_ff[i]  <= 9'h000;
                cfg_mem_ff[i]  <= 9'h000;
            end
            seq_addr_ff    <= 6'h00;
            eval_addr_ff   <= 6'h00;
            thr_addr_ff    <= 6'h00;
            cfg_addr_ff    <= 6'h00;
            second_pass_ff <= 1'b0;
            init_seen_ff   <= 1'b0;
        end
        else
        begin
            if (init_done)
                init_seen_ff <= 1'b1; // [RULE6]
            if (!init_seen_ff && !init_done) // [RULE16]
            begin
                if (seq_ram_load_en) // [RULE4] [RULE5]
                begin
                    seq_mem_ff[seq_addr_ff] <= init_data;
                    seq_addr_ff <= addr_inc(seq_addr_ff, `SQSP_SEQ_LAST);
                end
                if (eval_ram_load_en) // [RULE4] [RULE5]
                begin
                    eval_mem_ff[eval_addr_ff[4:0]] <= init_data;
                    eval_addr_ff <= addr_inc(eval_addr_ff, `SQSP_CH_LAST);
                end
                if (thresh_ram_load_en) // [RULE4] [RULE5]
                begin
                    thr_mem_ff[thr_addr_ff[4:0]] <= init_data;
                    thr_addr_ff <= addr_inc(thr_addr_ff, `SQSP_CH_LAST);
                end
                if (cfg_load) // [RULE4] [RULE5]
                begin
                    // the first second-pass word restarts the config mux address
                    if (cfg_mux_second_pass_en && !second_pass_ff)
                    begin
                        second_pass_ff <= 1'b1;
                        cfg_mem_ff[0]  <= init_data;
                        cfg_addr_ff    <= 6'h01;
                    end
                    else
                    begin
                        cfg_mem_ff[cfg_addr_ff[4:0]] <= init_data;
                        cfg_addr_ff <= addr_inc(cfg_addr_ff, `SQSP_CH_LAST);
                    end
                end
            end
        end
    end

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (init_seen_ff && ctrl_run)
                    nxt_state = ST_LATCH;
            ST_LATCH:
                nxt_state = ST_ACQ;
            ST_ACQ:
                if (acq_cnt_ff == 4'h0)
                    nxt_state = ST_CONV;
            ST_CONV:
                if (adc_conv_done)
                    nxt_state = ST_EVAL;
            ST_EVAL:
                if (seq_word[`SQSP_SEQ_WAIT_BIT])
                    nxt_state = ST_WAIT;
                else
                    nxt_state = ST_DONE;
            ST_WAIT:
                if (wait_cnt_ff == 4'h0)
                    nxt_state = ST_DONE;
            ST_DONE:
                if (ctrl_run)
                    nxt_state = ST_LATCH;
                else
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // sequencer and status outputs
    always @(posedge core_clk or negedge system_reset_low) // [RULE2] [RULE3]
    begin
        if (!system_reset_low)
        begin
            state_ff             <= ST_IDLE;
            slot_ff              <= 6'h00;
            ch_ff                <= 5'h00;
            acq_cnt_ff           <= 4'h0;
            wait_cnt_ff          <= 4'h0;
            conv_channel_select  <= 5'h00;
            conv_start           <= 1'b0;
            conv_result_port     <= `SQSP_RESULT_RESET;
            conv_result_valid    <= 1'b0;
            slot_complete        <= 1'b0;
            slot_wait_state      <= 1'b0;
            channel_saturated    <= 1'b0;
            channel_sel_captured <= 1'b0;
            compare_flags        <= `SQSP_FLAGS_RESET;
        end
        else
        begin
            state_ff             <= nxt_state;
            conv_start           <= 1'b0;
            slot_complete        <= 1'b0;
            channel_sel_captured <= 1'b0;
            case (state_ff)
                ST_IDLE:
                    // every run begins with the main procedure
                    slot_ff <= 6'h00; // [RULE15]
                ST_LATCH:
                begin
                    ch_ff                <= seq_word[`SQSP_SEQ_CH_MSB:0];
                    conv_channel_select  <= seq_word[`SQSP_SEQ_CH_MSB:0];
                    channel_sel_captured <= 1'b1; // [RULE12] [RULE1]
                    channel_saturated    <= 1'b0; // [RULE11]
                    conv_result_valid    <= 1'b0; // [RULE8]
                    acq_cnt_ff           <= cfg_mem_ff[seq_word[`SQSP_SEQ_CH_MSB:0]][3:0];
                end
                ST_ACQ:
                begin
                    if (acq_cnt_ff == 4'h0)
                        conv_start <= 1'b1;
                    else
                        acq_cnt_ff <= acq_cnt_ff - 4'h1;
                end
                ST_CONV:
                begin
                    if (adc_conv_done)
                    begin
                        conv_result_port  <= fmt_result; // [RULE14]
                        conv_result_valid <= 1'b1; // [RULE8]
                        channel_saturated <= fmt_saturated; // [RULE11]
                    end
                end
                ST_EVAL:
                begin
                    compare_flags[ch_ff] <= flag_eval(eval_mem_ff[ch_ff], thr_mem_ff[ch_ff],
                                                      conv_result_port); // [RULE13]
                    if (seq_word[`SQSP_SEQ_WAIT_BIT])
                    begin
                        wait_cnt_ff     <= `SQSP_WAIT_CYCLES - 4'h1;
                        slot_wait_state <= 1'b1; // [RULE10]
                    end
                end
                ST_WAIT:
                begin
                    if (wait_cnt_ff == 4'h0)
                        slot_wait_state <= 1'b0; // [RULE10]
                    else
                        wait_cnt_ff <= wait_cnt_ff - 4'h1;
                end
                ST_DONE:
                begin
                    slot_complete <= 1'b1; // [RULE9]
                    // an end mark or the last slot loops the procedure to slot 0
                    if (seq_word[`SQSP_SEQ_END_BIT] || slot_ff == `SQSP_SEQ_LAST)
                        slot_ff <= 6'h00;
                    else
                        slot_ff <= slot_ff + 6'h01;
                end
                default:
                    slot_ff <= 6'h00;
            endcase
        end
    end

    // avalon slave: fixed one wait cycle, so each access takes two edges
    always @(posedge core_clk or negedge system_reset_low) // [RULE2]
    begin
        if (!system_reset_low)
        begin
            avs_waitrequest    <= 1'b1;
            avs_readdata       <= 32'h00000000;
            bus_ack_pending_ff <= 1'b0;
            ctrl_ff            <= `SQSP_CTRL_RESET;
        end
        else
        begin
            if (bus_req && avs_waitrequest && !bus_ack_pending_ff)
            begin
                avs_waitrequest    <= 1'b0;
                bus_ack_pending_ff <= 1'b1;
                avs_readdata       <= 32'h00000000;
                if (avs_read)
                begin
                    case (avs_address)
                        `SQSP_REG_CTRL:
                            avs_readdata <= {28'h0000000, ctrl_ff};
                        `SQSP_REG_STATUS:
                            avs_readdata <= {17'h00000, state_ff, channel_saturated,
                                             init_seen_ff, slot_ff};
                        `SQSP_REG_RESULT:
                            avs_readdata <= {15'h0000, ch_ff, conv_result_port};
                        `SQSP_REG_FLAGS:
                            avs_readdata <= compare_flags;
                        default:
                            avs_readdata <= 32'h00000000;
                    endcase
                end
            end
            else
            begin
                avs_waitrequest    <= 1'b1;
                bus_ack_pending_ff <= 1'b0;
            end
            // control bits change only at the accepting edge
            if (bus_fire && avs_write && avs_address == `SQSP_REG_CTRL && avs_byteenable[0])
                ctrl_ff <= avs_writedata[3:0];
        end
    end

endmodule

// >>> verif/sqsp_checker.sv
// concurrent checks on the sequencer status ports
`timescale 1ns/1ps
module sqsp_checker (
    input wire        core_clk,
    input wire        system_reset_low,
    input wire [1:0]  avs_address,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    input wire        conv_start,
    input wire [11:0] conv_result_port,
    input wire        conv_result_valid,
    input wire        slot_complete,
    input wire        slot_wait_state,
    input wire        channel_saturated,
    input wire        channel_sel_captured,
    input wire [31:0] compare_flags
);
    reg [1:0] mode_ff;
    // shadow of the resolution field, only accepted control writes move it
    always @(posedge core_clk or negedge system_reset_low)
        if (!system_reset_low)
            mode_ff <= 2'h0;
        else if (avs_write && !avs_waitrequest && avs_address == 2'h0)
            mode_ff <= avs_writedata[2:1];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!system_reset_low);
    sequence s_wait_run;
        slot_wait_state [*4] ##1 !slot_wait_state;
    endsequence
    sequence s_capture;
        channel_sel_captured ##1 !channel_sel_captured;
    endsequence
    AST_RESET_OUT: assert property (disable iff (1'b0) !system_reset_low |-> !conv_result_valid
        && !slot_complete && !slot_wait_state && !channel_saturated && !channel_sel_captured
        && !conv_start && compare_flags == 32'h0 && avs_waitrequest) else $error("reset state");
    AST_WAIT_LEN: assert property ($rose(slot_wait_state) |-> s_wait_run)
        else $error("wait length");
    AST_CAPT_PULSE: assert property ($rose(channel_sel_captured) |-> s_capture)
        else $error("capture pulse");
    AST_CAPT_CLEARS: assert property (channel_sel_captured |-> !conv_result_valid
        && !channel_saturated) else $error("stale result at capture");
    AST_CAPT_TO_START: assert property (channel_sel_captured |-> ##[1:17] conv_start)
        else $error("no start after capture");
    AST_SAT_HOLD: assert property ($fell(channel_saturated) |-> channel_sel_captured)
        else $error("saturation dropped early");
    AST_SAT_VALID: assert property (channel_saturated |-> conv_result_valid)
        else $error("saturation without result");
    AST_LOW_BITS: assert property ($rose(conv_result_valid) |->
        (mode_ff != 2'h1 || conv_result_port[1:0] == 2'h0) &&
        (mode_ff != 2'h2 || conv_result_port[3:0] == 4'h0)) else $error("low bits set");
    AST_VALID_STABLE: assert property (conv_result_valid && $past(conv_result_valid) |->
        $stable(conv_result_port)) else $error("result moved");
    AST_DONE_PULSE: assert property (slot_complete |=> !slot_complete)
        else $error("done too long");
    AST_DONE_VALID: assert property (slot_complete |-> conv_result_valid && !slot_wait_state)
        else $error("done out of order");
    AST_AVS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
endmodule
bind sqsp_sequencer_top sqsp_checker u_chk (.*);

// >>> verif/sqsp_far_model.sv
// loader and converter model facing the sequencer
`timescale 1ns/1ps
module sqsp_far_model (
    input  wire        core_clk,
    input  wire        conv_start,
    input  wire [11:0] next_raw,
    output reg  [8:0]  init_data,
    output wire        cfg_mux_load_en,
    output wire        seq_ram_load_en,
    output wire        eval_ram_load_en,
    output wire        thresh_ram_load_en,
    output wire        cfg_mux_second_pass_en,
    output reg         init_done,
    output reg  [11:0] adc_result_raw,
    output reg         adc_conv_done
);
    reg [4:0] wen_ff = 5'h00;
    reg [2:0] dly_ff = 3'h0;
    reg       slow_ff = 1'b0;
    assign {cfg_mux_second_pass_en, thresh_ram_load_en, eval_ram_load_en,
            seq_ram_load_en, cfg_mux_load_en} = wen_ff;
    initial
    begin
        init_data = 9'h000;
        init_done = 1'b0;
        adc_result_raw = 12'h000;
        adc_conv_done = 1'b0;
    end
    task load_word(input [2:0] sel, input [8:0] d);
        begin
            @(posedge core_clk);
            wen_ff <= 5'h01 << sel;
            init_data <= d;
        end
    endtask
    task end_load;
        begin
            @(posedge core_clk);
            wen_ff <= 5'h00;
            init_data <= ~init_data;
            init_done <= 1'b1;
        end
    endtask
    // answers alternate quick and slow; the bus shows junk between answers
    always @(posedge core_clk)
    begin
        adc_conv_done <= 1'b0;
        adc_result_raw <= ~adc_result_raw;
        if (conv_start === 1'b1)
        begin
            dly_ff <= slow_ff ? 3'h5 : 3'h1;
            slow_ff <= ~slow_ff;
        end
        else if (dly_ff == 3'h1)
        begin
            adc_conv_done <= 1'b1;
            adc_result_raw <= next_raw;
            dly_ff <= 3'h0;
        end
        else if (dly_ff != 3'h0)
            dly_ff <= dly_ff - 3'h1;
    end
endmodule

// >>> verif/tb.sv
// self-checking bench for the sample sequencer status block
`timescale 1ns/1ps
module tb;
    reg         core_clk = 1'b0;
    reg         system_reset_low = 1'b1;
    reg  [1:0]  avs_address = 2'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [11:0] next_raw = 12'h0;
    wire [8:0]  init_data;
    wire        init_done, cfg_mux_load_en, seq_ram_load_en, eval_ram_load_en, conv_start;
    wire        thresh_ram_load_en, cfg_mux_second_pass_en, adc_conv_done;
    wire [3:0]  avs_byteenable = 4'hF;
    wire        conv_result_valid, slot_complete, slot_wait_state, channel_saturated;
    wire        channel_sel_captured, avs_waitrequest;
    wire [11:0] adc_result_raw, conv_result_port;
    wire [4:0]  conv_channel_select;
    wire [31:0] compare_flags, avs_readdata;
    integer     miscompares = 0, check_count = 0, m, k;
    reg  [31:0] lfsr = 32'h883e, exp_flags = 32'h0, rd = 32'h0;
    reg  [1:0]  mode = 2'h0, conv_cnt = 2'h0;
    reg         ch_idx = 1'b0, valid_q = 1'b0;
    reg  [16:0] last_rc = 17'h0;
    reg  [11:0] raw;
    reg  [12:0] e;
    reg  [63:0] er;
    reg  [12:0] exp_res[$];
    reg  [63:0] exp_rd[$];
    always #20 core_clk = ~core_clk;
    sqsp_sequencer_top uut (.*);
    sqsp_far_model u_far (.*);
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // saturation means all ones at the active resolution
    function [12:0] fmt(input [11:0] r, input [1:0] md);
        reg [11:0] lm;
        begin
            lm = (md == 2'h1) ? 12'h003 : (md == 2'h2) ? 12'h00F : 12'h000;
            fmt = {(r | lm) == 12'hFFF, r & ~lm};
        end
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks=%0d miscompares=%0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // for reads d is the expected word under mask
    task avs(input wr, input [1:0] a, input [31:0] d, input [31:0] mask);
        integer n;
        begin
            @(posedge core_clk);
            avs_address <= a;
            avs_read <= !wr;
            avs_write <= wr;
            avs_writedata <= d;
            if (!wr)
                exp_rd.push_back({mask, d});
            n = 0;
            @(posedge core_clk);
            while (avs_waitrequest !== 1'b0 && n < 50)
            begin
                @(posedge core_clk);
                n = n + 1;
            end
            rd = avs_readdata;
            if (n >= 50)
                miscompares = miscompares + 1;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task wait_slots(input integer cnt);
        integer n;
        begin
            n = 0;
            while (cnt > 0 && n < 3000)
            begin
                @(posedge core_clk);
                n = n + 1;
                if (slot_complete === 1'b1)
                    cnt = cnt - 1;
            end
            if (cnt > 0)
                miscompares = miscompares + 1;
        end
    endtask
    // every fourth conversion is full scale; threshold ties are steered away
    always @(posedge core_clk)
        if (conv_start === 1'b1)
        begin
            lfsr = lfsr_next(lfsr);
            raw = (conv_cnt == 2'h3) ? 12'hFFF : lfsr[11:0];
            if (raw[11:4] == 8'h80 || raw[11:4] == 8'h40)
                raw = raw ^ 12'h010;
            conv_cnt <= conv_cnt + 2'h1;
            next_raw <= raw;
            exp_res.push_back(fmt(raw, mode));
        end
    always @(posedge core_clk)
    begin
        valid_q <= conv_result_valid;
        if (conv_result_valid === 1'b1 && valid_q === 1'b0 && exp_res.size() > 0)
        begin
            e = exp_res.pop_front();
            check(conv_result_port, e[11:0]);
            check(channel_saturated, e[12]);
            last_rc = {conv_channel_select, e[11:0]};
            if (conv_channel_select == 5'h03)
                exp_flags[3] = e[11:4] < 8'h80;
            if (conv_channel_select == 5'h05)
                exp_flags[5] = e[11:4] > 8'h40;
        end
        if (channel_sel_captured === 1'b1)
        begin
            check(conv_channel_select, ch_idx ? 5'h05 : 5'h03);
            ch_idx = ~ch_idx;
        end
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_rd.size() > 0)
        begin
            er = exp_rd.pop_front();
            check(avs_readdata & er[63:32], er[31:0] & er[63:32]);
        end
    end
    initial
    begin
        #2000000;
        miscompares = miscompares + 1;
        give_verdict;
    end
    initial
    begin
        // a falling edge at time zero resets the block before the first clock edge
        system_reset_low <= 1'b0;
        repeat (2) @(posedge core_clk);
        system_reset_low <= 1'b1;
        avs(0, 2'h0, 32'h0, 32'hFFFFFFFF);
        avs(0, 2'h1, 32'h100, 32'h7FFF);
        u_far.load_word(0, 9'h000);
        u_far.load_word(4, 9'h000);
        u_far.load_word(1, 9'h023);
        u_far.load_word(1, 9'h045);
        for (k = 0; k < 6; k = k + 1)
            u_far.load_word(2, (k == 3) ? 9'h001 : 9'h000);
        for (k = 0; k < 6; k = k + 1)
            u_far.load_word(3, (k == 3) ? 9'h180 : (k == 5) ? 9'h140 : 9'h000);
        u_far.end_load;
        avs(0, 2'h1, 32'h140, 32'h7FFF);
        for (m = 0; m < 3; m = m + 1)
        begin
            mode = m;
            ch_idx = 1'b0;
            avs(1, 2'h0, {29'h0, mode, 1'b1}, 32'h0);
            wait_slots(6);
            avs(1, 2'h0, {29'h0, mode, 1'b0}, 32'h0);
            rd = 32'h0;
            for (k = 0; k < 40 && rd[14:8] !== 7'h01; k = k + 1)
                avs(0, 2'h1, 32'h0, 32'h0);
            avs(0, 2'h2, {15'h0, last_rc}, 32'h1FFFF);
            avs(0, 2'h3, exp_flags, 32'hFFFFFFFF);
            check(compare_flags, exp_flags);
        end
        mode = 2'h0;
        ch_idx = 1'b0;
        avs(1, 2'h0, 32'h1, 32'h0);
        for (k = 0; k < 200 && conv_result_valid !== 1'b1; k = k + 1)
            @(posedge core_clk);
        system_reset_low <= 1'b0;
        #5;
        check({conv_result_valid, channel_saturated, avs_waitrequest}, 32'h1);
        check(compare_flags, 32'h0);
        exp_res.delete();
        @(posedge core_clk);
        system_reset_low <= 1'b1;
        give_verdict;
    end
endmodule
